/* File: mps_pair_steer.sv */
/*
  mps_pair_steer: steers twisted pairs A/B between straight and crossed
  roles, holds extended control register two, drives speed and LED pins,
  samples the PHY address at reset release.
  Assumes a management engine on ref_clk presenting register index and
  strobes, and an analog front end that gives energy detect per pair.
*/
`timescale 1ns/1ps
// Functional notes
// R1: straight drives pair A, receives pair B
// R2: crossed drives pair B, receives pair A
// R3: auto crossover enable at reg 13h bit 9
// R4: forced pair select at reg 13h bit 8
// R5: enable pin reads high when unconnected
// R6: hiz bit tri-states transmit outputs
// R7: auto power-down of 100M at 10M
// R8: isolate also powers down 100M
// R9: speed output high at 100 Mb/s
// R10: five pins give address, then LEDs
// R11: system pulls reset low to reset
// R12: system supplies 25 MHz reference clock; slot timing assumes 100 MHz
// R13: auto crossover on by default after reset
// R14: auto only when pin and bit both one
// R15: auto choice by slot toggling before link
module mps_pair_steer (
  input wire logic ref_clk,
  input wire logic rst_b,
  // management register port
  input wire logic [4:0] mgmt_reg_addr,
  input wire logic mgmt_wr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  input wire logic isolate,
  input wire logic remote_fault,
  // automatic crossover pin, pulled up outside when open
  input wire logic auto_crossover_enable,
  // line side
  input wire logic link_up,
  input wire logic speed_100,
  input wire logic pair_a_energy,
  input wire logic pair_b_energy,
  input wire logic line_tx_pos,
  input wire logic line_tx_neg,
  output logic pair_a_pos_o,
  output logic pair_a_pos_oe,
  output logic pair_a_neg_o,
  output logic pair_a_neg_oe,
  output logic pair_b_pos_o,
  output logic pair_b_pos_oe,
  output logic pair_b_neg_o,
  output logic pair_b_neg_oe,
  input wire logic pair_a_pos_i,
  input wire logic pair_a_neg_i,
  input wire logic pair_b_pos_i,
  input wire logic pair_b_neg_i,
  output logic line_rx_pos,
  output logic line_rx_neg,
  output logic crossed,
  output logic hs_xcvr_pd,
  output logic speed_ind,
  // multiplexed address / LED pins
  input wire logic addr4_rx_led_i,
  input wire logic addr3_tx_led_i,
  input wire logic addr2_link_led_i,
  input wire logic addr1_collision_led_i,
  input wire logic addr0_activity_led_i,
  output logic addr4_rx_led_o,
  output logic addr3_tx_led_o,
  output logic addr2_link_led_o,
  output logic addr1_collision_led_o,
  output logic addr0_activity_led_o,
  output logic [4:0] led_oe,
  input wire logic rx_act,
  input wire logic tx_act,
  input wire logic coll_act,
  output logic [4:0] phy_address
);
  import mps_pkg::*;
  typedef enum logic [2:0] {
    MPS_ST_SAMPLE = 3'b001,
    MPS_ST_HUNT = 3'b010,
    MPS_ST_LOCK = 3'b100
  } mps_state_t;

  mps_state_t state_ff;
  mps_state_t nxt_state;
  logic [15:0] ctrl_ff;
  logic auto_xo_pin;
  logic [4:0] addr_pins;
  logic [4:0] addr_sync;
  logic [4:0] phy_address_ff;
  logic [1:0] sample_cnt_ff;
  logic [31:0] slot_cnt_ff;
  logic [15:0] lfsr_ff;
  logic auto_cross_ff;
  logic crossed_ff;
  logic nxt_crossed;
  logic auto_mode;
  logic slot_end;
  logic pair_act;
  logic [4:0] led_act;
  logic [4:0] led_out_ff;
  logic hs_pd_ff;
  logic speed_ind_ff;

  // pin enters on the pull-up level so an open pin means enabled
  mps_sync #(.RST_VAL(1'b1)) u_xo_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pin_in(auto_crossover_enable),
    .pin_sync(auto_xo_pin) // R5
  );

  assign addr_pins = {addr4_rx_led_i, addr3_tx_led_i, addr2_link_led_i,
                      addr1_collision_led_i, addr0_activity_led_i};

  // address straps synchronised before sampling
  genvar gi;
  generate
    for (gi = 0; gi < MPS_ADDR_W; gi++) begin : g_addr
      mps_sync #(.RST_VAL(1'b0)) u_addr_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in(addr_pins[gi]),
        .pin_sync(addr_sync[gi])
      );
    end
  endgenerate

  // extended control register two, bits outside the write mask cleared on write
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= MPS_EXT_CTRL2_RST; // R13
    end else if (mgmt_wr && mgmt_reg_addr == MPS_REG_EXT_CTRL2) begin
      ctrl_ff <= mgmt_wdata & MPS_EXT_CTRL2_WMASK; // R3 R4
    end
  end

  // read path; node and software mode are fixed, fault is live
  always_comb begin
    mgmt_rdata = 16'h0000;
    if (mgmt_reg_addr == MPS_REG_EXT_CTRL2) begin
      mgmt_rdata = ctrl_ff;
      mgmt_rdata[MPS_BIT_NODE] = 1'b0;
      mgmt_rdata[MPS_BIT_SWMODE] = 1'b1;
      mgmt_rdata[MPS_BIT_RFAULT] = remote_fault;
    end
  end

  // auto only when both pin and register bit enable it
  assign auto_mode = auto_xo_pin && ctrl_ff[MPS_BIT_AUTO_XO]; // R14

  // state: sample straps after reset, hunt for pair, hold on link
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      MPS_ST_SAMPLE: begin
        if (sample_cnt_ff == 2'(MPS_SAMPLE_CYC)) begin
          nxt_state = MPS_ST_HUNT;
        end
      end
      MPS_ST_HUNT: begin
        if (link_up) begin
          nxt_state = MPS_ST_LOCK;
        end
      end
      MPS_ST_LOCK: begin
        if (!link_up) begin
          nxt_state = MPS_ST_HUNT;
        end
      end
      default: begin
        nxt_state = MPS_ST_SAMPLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= MPS_ST_SAMPLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // strap settling counter; waits for the synchronisers to fill
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_cnt_ff <= 2'b00;
    end else if (state_ff == MPS_ST_SAMPLE) begin
      sample_cnt_ff <= sample_cnt_ff + 2'b01;
    end
  end

  // address latched once at leaving the sample state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phy_address_ff <= 5'h00;
    end else if (state_ff == MPS_ST_SAMPLE && nxt_state == MPS_ST_HUNT) begin
      phy_address_ff <= addr_sync; // R10
    end
  end
  assign phy_address = phy_address_ff;

  // slot timer and random source for the hunt
  assign slot_end = (slot_cnt_ff == 32'(MPS_SLOT_CYC - 1));
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      slot_cnt_ff <= 32'h0000_0000;
      lfsr_ff <= MPS_LFSR_SEED;
    end else begin
      lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
      if (slot_end || state_ff != MPS_ST_HUNT) begin
        slot_cnt_ff <= 32'h0000_0000;
      end else begin
        slot_cnt_ff <= slot_cnt_ff + 32'h0000_0001;
      end
    end
  end

  // hunt: no energy on the current receive pair ends a slot with a
  // random keep-or-swap, so two auto ends cannot lock step forever
  assign pair_act = auto_cross_ff ? pair_a_energy : pair_b_energy;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      auto_cross_ff <= 1'b0;
    end else if (state_ff == MPS_ST_HUNT && slot_end && !pair_act && lfsr_ff[0]) begin
      auto_cross_ff <= !auto_cross_ff; // R15
    end
  end

  // final pair selection
  always_comb begin
    if (auto_mode) begin
      nxt_crossed = auto_cross_ff; // R14
    end else if (!ctrl_ff[MPS_BIT_AUTO_XO]) begin
      nxt_crossed = ctrl_ff[MPS_BIT_FORCE_SEL]; // R4
    end else begin
      nxt_crossed = 1'b0; // R14
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      crossed_ff <= 1'b0;
    end else begin
      crossed_ff <= nxt_crossed;
    end
  end
  assign crossed = crossed_ff;

  // transmit steering; the hiz bit releases both drivers
  always_comb begin
    pair_a_pos_o = crossed_ff ? 1'b0 : line_tx_pos; // R1
    pair_a_neg_o = crossed_ff ? 1'b0 : line_tx_neg; // R1
    pair_b_pos_o = crossed_ff ? line_tx_pos : 1'b0; // R2
    pair_b_neg_o = crossed_ff ? line_tx_neg : 1'b0; // R2
    pair_a_pos_oe = !crossed_ff && !ctrl_ff[MPS_BIT_HIZ]; // R6
    pair_a_neg_oe = !crossed_ff && !ctrl_ff[MPS_BIT_HIZ]; // R6
    pair_b_pos_oe = crossed_ff && !ctrl_ff[MPS_BIT_HIZ]; // R6
    pair_b_neg_oe = crossed_ff && !ctrl_ff[MPS_BIT_HIZ]; // R6
  end

  // receive steering from the pair not transmitting
  assign line_rx_pos = crossed_ff ? pair_a_pos_i : pair_b_pos_i; // R1 R2
  assign line_rx_neg = crossed_ff ? pair_a_neg_i : pair_b_neg_i; // R1 R2

  // 100M transceiver power-down: auto at 10M, or when isolated
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hs_pd_ff <= 1'b0;
    end else begin
      hs_pd_ff <= (ctrl_ff[MPS_BIT_AUTO_PD] && link_up && !speed_100) // R7
                  || isolate; // R8
    end
  end
  assign hs_xcvr_pd = hs_pd_ff;

  // speed pin follows the link rate, one cycle late so it never glitches
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      speed_ind_ff <= 1'b0;
    end else begin
      speed_ind_ff <= link_up && speed_100; // R9
    end
  end
  assign speed_ind = speed_ind_ff;

  // LEDs assert at the inverse of the sampled strap level
  assign led_act = {rx_act, tx_act, link_up, coll_act, rx_act || tx_act};
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      led_out_ff <= 5'h00;
    end else begin
      led_out_ff <= led_act ^ phy_address_ff; // R10
    end
  end

  // pins stay inputs until the straps are taken
  assign led_oe = (state_ff == MPS_ST_SAMPLE) ? 5'h00 : 5'h1F; // R10
  assign addr4_rx_led_o = led_out_ff[4];
  assign addr3_tx_led_o = led_out_ff[3];
  assign addr2_link_led_o = led_out_ff[2];
  assign addr1_collision_led_o = led_out_ff[1];
  assign addr0_activity_led_o = led_out_ff[0];
endmodule

/* File: mps_pkg.sv */
/*
  mps_pkg: constants for the pair steering control block.
  Assumes a single 100 MHz clock domain and a management write/read port
  that presents register index, data and strobes directly.
*/
package mps_pkg;
  localparam logic [4:0] MPS_REG_EXT_CTRL2 = 5'h13;
  localparam logic [4:0] MPS_REG_BASIC_CTRL = 5'h00;
  localparam int MPS_BIT_NODE = 15;
  localparam int MPS_BIT_SWMODE = 14;
  localparam int MPS_BIT_RFAULT = 13;
  localparam int MPS_BIT_AUTO_XO = 9;
  localparam int MPS_BIT_FORCE_SEL = 8;
  localparam int MPS_BIT_HIZ = 7;
  localparam int MPS_BIT_AUTO_PD = 0;
  localparam int MPS_BIT_ISOLATE = 10;
  localparam logic [15:0] MPS_EXT_CTRL2_RST = 16'h4201;
  // writable bits: 12:11, 9:0
  localparam logic [15:0] MPS_EXT_CTRL2_WMASK = 16'h1BFF;
  // auto crossover slot timing
  localparam int MPS_CLK_MHZ = 100;
  localparam int MPS_SLOT_US = 1000;
  localparam int MPS_SLOT_CYC = MPS_SLOT_US * MPS_CLK_MHZ;
  localparam logic [15:0] MPS_LFSR_SEED = 16'hACE1;
  localparam int MPS_ADDR_W = 5;
  localparam int MPS_SAMPLE_CYC = 2;
endpackage

/* File: mps_sync.sv */
/*
  mps_sync: two-flop synchroniser for one pin level.
  Assumes the pin is asynchronous to ref_clk.
*/
`timescale 1ns/1ps
module mps_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic pin_in,
  output logic pin_sync
);
  logic meta_ff;

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= RST_VAL;
      pin_sync <= RST_VAL;
    end else begin
      meta_ff <= pin_in;
      pin_sync <= meta_ff;
    end
  end
endmodule

/* File: mps_pair_steer_assertions.sv */
/*
  checker for the pair steering block: pair roles, tri-state, power-down, speed.
  assumes it is bound to mps_pair_steer and sees only its ports.
*/
`timescale 1ns/1ps
module mps_pair_steer_chk (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [4:0] mgmt_reg_addr,
  input wire logic [15:0] mgmt_rdata,
  input wire logic isolate,
  input wire logic auto_crossover_enable,
  input wire logic link_up,
  input wire logic speed_100,
  input wire logic line_tx_pos,
  input wire logic pair_a_pos_o,
  input wire logic pair_a_pos_oe,
  input wire logic pair_a_neg_oe,
  input wire logic pair_b_pos_o,
  input wire logic pair_b_pos_oe,
  input wire logic pair_b_neg_oe,
  input wire logic pair_a_pos_i,
  input wire logic pair_b_pos_i,
  input wire logic line_rx_pos,
  input wire logic crossed,
  input wire logic hs_xcvr_pd,
  input wire logic speed_ind
);
  import mps_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // register bits are only visible while the port addresses 13h
  wire logic sel13 = mgmt_reg_addr == MPS_REG_EXT_CTRL2;
  property p_straight; !crossed |-> pair_a_pos_o == line_tx_pos && line_rx_pos == pair_b_pos_i; endproperty
  a_straight: assert property (p_straight) else $error("straight pair roles wrong");
  property p_cross; crossed |-> pair_b_pos_o == line_tx_pos && line_rx_pos == pair_a_pos_i; endproperty
  a_cross: assert property (p_cross) else $error("crossed pair roles wrong");
  property p_hiz; sel13 && mgmt_rdata[MPS_BIT_HIZ] |-> !(pair_a_pos_oe || pair_a_neg_oe || pair_b_pos_oe || pair_b_neg_oe); endproperty
  a_hiz: assert property (p_hiz) else $error("line driver enabled while tri-stated");
  property p_drive; sel13 && !mgmt_rdata[MPS_BIT_HIZ] |-> (crossed ? pair_b_pos_oe && pair_b_neg_oe : pair_a_pos_oe && pair_a_neg_oe); endproperty
  a_drive: assert property (p_drive) else $error("transmit pair not driven");
  property p_force; sel13 && !mgmt_rdata[MPS_BIT_AUTO_XO] |=> crossed == $past(mgmt_rdata[MPS_BIT_FORCE_SEL]); endproperty
  a_force: assert property (p_force) else $error("forced pair select not followed");
  property p_pin_low; (!auto_crossover_enable && sel13 && mgmt_rdata[MPS_BIT_AUTO_XO])[*4] |=> !crossed; endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin low did not force straight");
  property p_pd; sel13 |=> hs_xcvr_pd == $past((mgmt_rdata[MPS_BIT_AUTO_PD] && link_up && !speed_100) || isolate); endproperty
  a_pd: assert property (p_pd) else $error("power-down state wrong");
  property p_iso; isolate |=> hs_xcvr_pd; endproperty
  a_iso: assert property (p_iso) else $error("isolate did not power down");
  property p_speed; 1'b1 |=> speed_ind == $past(link_up && speed_100); endproperty
  a_speed: assert property (p_speed) else $error("speed output wrong");
  property p_rst; $rose(rst_b) && sel13 |-> (mgmt_rdata & 16'hDFFF) == MPS_EXT_CTRL2_RST; endproperty
  a_rst: assert property (p_rst) else $error("control register reset value wrong");
  c_crossed: cover property (crossed);
  c_pd: cover property (hs_xcvr_pd && !isolate);
  c_hiz: cover property (sel13 && mgmt_rdata[MPS_BIT_HIZ]);
endmodule
bind mps_pair_steer mps_pair_steer_chk u_chk (.*);

/* File: mps_sta_model.sv */
/*
  station manager model: one-cycle register writes and address setup for reads.
  assumes the block takes a write on the edge where mgmt_wr is high.
*/
`timescale 1ns/1ps
module mps_sta_model (
  input wire logic ref_clk,
  output logic [4:0] mgmt_reg_addr,
  output logic mgmt_wr,
  output logic [15:0] mgmt_wdata
);
  initial begin
    mgmt_reg_addr = 5'h13;
    mgmt_wr = 1'b0;
    mgmt_wdata = 16'h0000;
  end
  // address stays after the strobe so reads see it; data is inverted once released
  task automatic xfer(input logic [4:0] a, input logic [15:0] d, input logic w);
    @(posedge ref_clk);
    mgmt_reg_addr <= a;
    mgmt_wdata <= d;
    mgmt_wr <= w;
    @(posedge ref_clk);
    mgmt_wr <= 1'b0;
    mgmt_wdata <= ~d;
  endtask
endmodule

/* File: mps_pair_steering_control_tb_top.sv */
/*
  testbench for the pair steering block, expectations queued and checked by a monitor.
  assumes mps_sta_model drives the register port and the checker is bound.
*/
`timescale 1ns/1ps
module mps_pair_steering_control_tb_top;
  import mps_pkg::*;
  logic ref_clk, rst_b, mgmt_wr, isolate, remote_fault, auto_crossover_enable, link_up, speed_100;
  logic pair_a_energy, pair_b_energy, line_tx_pos, line_tx_neg, pair_a_pos_i, pair_a_neg_i, pair_b_pos_i;
  logic pair_b_neg_i, pair_a_pos_o, pair_a_pos_oe, pair_a_neg_o, pair_a_neg_oe, pair_b_pos_o, pair_b_pos_oe;
  logic pair_b_neg_o, pair_b_neg_oe, line_rx_pos, line_rx_neg, crossed, hs_xcvr_pd, speed_ind;
  logic addr4_rx_led_i, addr3_tx_led_i, addr2_link_led_i, addr1_collision_led_i, addr0_activity_led_i;
  logic addr4_rx_led_o, addr3_tx_led_o, addr2_link_led_o, addr1_collision_led_o, addr0_activity_led_o;
  logic rx_act, tx_act, coll_act;
  logic [4:0] mgmt_reg_addr, led_oe, phy_address, strap;
  logic [15:0] mgmt_wdata, mgmt_rdata;
  logic [15:0] exp_q[$];
  int sel_q[$];
  int err_count, total_checks;
  event probe;
  string names[7] = '{"rdata", "steer", "pair_a", "pair_b", "power", "leds", "address"};
  assign {addr4_rx_led_i, addr3_tx_led_i, addr2_link_led_i, addr1_collision_led_i, addr0_activity_led_i} = strap;
  mps_pair_steer uut (.*);
  mps_sta_model u_sta (.*);
  always #5 ref_clk = ~ref_clk;
  function automatic logic [15:0] obs(input int s);
    case (s)
      0: return mgmt_rdata;
      1: return {9'h0, crossed, pair_a_pos_oe, pair_a_neg_oe, pair_b_pos_oe, pair_b_neg_oe, line_rx_pos, line_rx_neg};
      2: return {14'h0, pair_a_pos_o, pair_a_neg_o};
      3: return {14'h0, pair_b_pos_o, pair_b_neg_o};
      4: return {14'h0, hs_xcvr_pd, speed_ind};
      5: return {6'h0, led_oe, addr4_rx_led_o, addr3_tx_led_o, addr2_link_led_o, addr1_collision_led_o,
                 addr0_activity_led_o};
      default: return {11'h0, phy_address};
    endcase
  endfunction
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // notes land mid-cycle so the monitor samples settled outputs
  task automatic chk(input int s, input logic [15:0] e);
    @(negedge ref_clk);
    exp_q.push_back(e);
    sel_q.push_back(s);
    ->probe;
  endtask
  task automatic go(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic test_done;
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // monitor: oldest note against what the outputs show now
  always @(probe) begin
    check(names[sel_q[0]], obs(sel_q[0]), exp_q[0]);
    void'(sel_q.pop_front());
    void'(exp_q.pop_front());
  end
  // watchdog far beyond the hundred or so cycles the sequence needs
  initial begin
    #200000;
    err_count++;
    test_done();
  end
  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    {isolate, remote_fault, link_up, speed_100, pair_a_energy, pair_b_energy} = 6'h00;
    auto_crossover_enable = 1'b1;
    {line_tx_pos, line_tx_neg, pair_a_pos_i, pair_a_neg_i, pair_b_pos_i, pair_b_neg_i} = 6'h00;
    {rx_act, tx_act, coll_act} = 3'h0;
    err_count = 0;
    total_checks = 0;
    void'($urandom(83));
    strap = 5'($urandom);
    go(20);
    rst_b <= 1'b1;
    go(6);
    chk(6, {11'h0, strap});
    chk(0, MPS_EXT_CTRL2_RST);
    go(1);
    rx_act <= 1'b1;
    go(3);
    chk(5, {6'h0, 5'h1F, strap ^ 5'h11});
    // forced straight then crossed, random line data each time
    for (int m = 0; m < 2; m++) begin
      u_sta.xfer(5'h13, 16'h0001 | (16'(m) << 8), 1'b1);
      {line_tx_pos, line_tx_neg, pair_a_pos_i, pair_a_neg_i, pair_b_pos_i, pair_b_neg_i} <= 6'($urandom);
      go(3);
      chk(1, m ? {10'h1, 4'h3, pair_a_pos_i, pair_a_neg_i} : {10'h0, 4'hC, pair_b_pos_i, pair_b_neg_i});
      chk(m ? 3 : 2, {14'h0, line_tx_pos, line_tx_neg});
    end
    u_sta.xfer(5'h13, 16'h0300, 1'b1);
    auto_crossover_enable <= 1'b0;
    go(6);
    chk(1, {10'h0, 4'hC, pair_b_pos_i, pair_b_neg_i});
    go(1);
    auto_crossover_enable <= 1'b1;
    u_sta.xfer(5'h13, 16'h0080, 1'b1);
    go(2);
    chk(1, {10'h0, 4'h0, pair_b_pos_i, pair_b_neg_i});
    u_sta.xfer(5'h13, 16'h0000, 1'b1);
    go(2);
    chk(1, {10'h0, 4'hC, pair_b_pos_i, pair_b_neg_i});
    go(1);
    remote_fault <= 1'b1;
    u_sta.xfer(5'h13, 16'hFFFF, 1'b1);
    u_sta.xfer(5'h05, 16'h0000, 1'b1);
    go(1);
    chk(0, 16'h0000);
    u_sta.xfer(5'h13, 16'h0000, 1'b0);
    go(1);
    chk(0, 16'h7BFF);
    go(1);
    link_up <= 1'b1;
    // table of auto power-down, speed and isolate cases
    for (int i = 0; i < 4; i++) begin
      u_sta.xfer(5'h13, {15'h0, i < 2}, 1'b1);
      speed_100 <= (i == 1);
      isolate <= (i == 3);
      go(3);
      chk(4, {14'h0, i == 0 || i == 3, i == 1});
    end
    go(2);
    test_done();
  end
endmodule
